// ==== nibble_alu_logic_skip_ops.v ====
/*
 * Nibble datapath with subtract-with-borrow, logic and skip operations,
 * reached over APB. Holds its own nibble data memory, which also hosts
 * the general registers.
 *
 * Register words, data in the low bits, unused bits read as zero:
 *   0x00  instruction; a write executes it, a read returns the last one
 *         [15:11] major opcode, [10:8] row, [7:4] column,
 *         [3:0] immediate nibble or general register column
 *   0x04  flags: carry, zero, compare only, decimal, index enable
 *   0x08  index value, ORed into the operand address when enabled
 *   0x0C  row of the memory that serves as general registers
 *   0x10  host pointer into the nibble memory
 *   0x14  nibble at the host pointer, read and write
 *   0x18  status: pending skip in bit 0, last result in [7:4]
 *
 * Major opcodes: 0x13 subtract immediate with borrow; 0x04, 0x06, 0x05
 * AND, OR, XOR of register and memory; 0x14, 0x16, 0x15 AND, OR, XOR of
 * memory and immediate; 0x1E skip if mask bits set; 0x1F skip if clear.
 *
 * Operand address is {row, column}; general register address is
 * {register row, low nibble} and is never indexed. Decimal subtraction
 * expects valid digits; on a borrow it adds ten back to the nibble.
 *
 * Assumes an APB master on clk. The slave answers with zero wait
 * states, so every access phase lasts one cycle. Any other address
 * answers with an error and is otherwise ignored. The nibble memory
 * has no reset: software fills it before use. A pending skip turns the
 * next instruction write into a no-op, whatever that instruction is.
 */
// Our own choices: the address map and register access over APB.
// Notes on behaviour
// - Opcode 10011 is subtract immediate with borrow from a memory nibble.
// - Compare clear: memory minus immediate minus carry written back to memory.
// - Compare set: difference discarded, carry and zero still updated.
// - Carry set on borrow, cleared without borrow.
// - Nonzero clears zero; zero result sets it only when compare is clear.
// - Decimal flag in status word picks binary or decimal subtraction.
// - Register OR memory written into the general register.
// - Memory OR immediate written back to memory.
// - Opcode 00100 is register AND memory into the general register.
// - Memory AND immediate written back to memory.
// - Register XOR memory written into the general register.
// - Opcode 10101 is memory XOR immediate written back to memory.
// - Skip-if-set clears compare; skips next when all mask bits set.
// - Skip-if-clear clears compare; skips next when masked bits zero.
// - With index enabled, operand address is index OR instruction address.
`timescale 1ns/1ps
`include "nibble_alu_map.vh"

module nibble_alu_logic_skip_ops #(
	parameter ROW_BITS = 3,
	parameter COL_BITS = 4
) (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	output reg         skip_request,
	output reg         borrow_carry_flag
);

	// Memory address width and depth from the row and column widths
	localparam ADDR_BITS = ROW_BITS + COL_BITS;
	localparam DEPTH     = 1 << ADDR_BITS;

	// Nibble memory; general registers are one row of it
	reg [3:0]           mem [0:DEPTH-1];
	// Program status word flags
	reg                 zero_flag;
	reg                 compare_only_flag;
	reg                 decimal_flag;
	reg                 index_enable_flag;
	reg [ADDR_BITS-1:0] index_register_value;
	// Host pointers and the history read back as status
	reg [ROW_BITS-1:0]  reg_row;
	reg [ADDR_BITS-1:0] host_addr;
	reg [15:0]          last_instr;
	reg [3:0]           last_result;

	// APB phase decode and instruction word fields
	wire       setup_phase = psel & ~penable;
	wire       access      = psel & penable;
	wire       bus_write   = access & pwrite;
	wire [4:0] op          = pwdata[`INS_OP_HI:`INS_OP_LO];
	wire [3:0] immediate_nibble = pwdata[`INS_NIB_HI:`INS_NIB_LO];
	wire [ROW_BITS-1:0] memory_row_field = pwdata[`INS_ROW_LO+ROW_BITS-1:`INS_ROW_LO];
	wire [COL_BITS-1:0] memory_column_field = pwdata[`INS_COL_HI:`INS_COL_LO];

	// Address decode, used only for the error answer
	function is_mapped;
		input [7:0] a;
		begin
			is_mapped = (a == `OFS_INSTR) || (a == `OFS_FLAGS) ||
				(a == `OFS_INDEX) || (a == `OFS_REG_ROW) ||
				(a == `OFS_MEM_ADDR) || (a == `OFS_MEM_DATA) ||
				(a == `OFS_STATUS);
		end
	endfunction

	// Zero wait states; unmapped addresses answer with an error
	assign pready  = 1'b1;
	assign pslverr = access & ~is_mapped(paddr);

	// An instruction executes at its access edge
	wire instr_wr = bus_write & (paddr == `OFS_INSTR);

	// Effective memory address with optional index OR
	wire [ADDR_BITS-1:0] inst_addr = {memory_row_field, memory_column_field};
	wire [ADDR_BITS-1:0] mem_addr  = index_enable_flag ?
		(index_register_value | inst_addr) : inst_addr;
	wire [ADDR_BITS-1:0] gpr_addr  = {reg_row, immediate_nibble};
	wire [3:0]           mem_val   = mem[mem_addr];
	wire [3:0]           gpr_val   = mem[gpr_addr];

	// Subtractor outputs
	wire [3:0] sub_diff;
	wire       sub_borrow;

	// Subtractor on memory nibble, immediate and carry
	nibble_sub u_sub (
		.minuend    (mem_val),
		.subtrahend (immediate_nibble),
		.borrow_in  (borrow_carry_flag),
		.decimal    (decimal_flag),
		.difference (sub_diff),
		.borrow_out (sub_borrow)
	);

	// Operation decode and result selection
	reg       next_wr_mem;
	reg       next_wr_gpr;
	reg       is_sub;
	reg       is_skip;
	reg       skip_hit;
	reg [3:0] result;

	always @* begin
		next_wr_mem = 1'b0;
		next_wr_gpr = 1'b0;
		is_sub      = 1'b0;
		is_skip     = 1'b0;
		skip_hit    = 1'b0;
		result      = 4'h0;
		case (op)
			`OP_SUBTRACT_WITH_BORROW_OP_IMM: begin
				is_sub      = 1'b1;
				result      = sub_diff;
				next_wr_mem = ~compare_only_flag;
			end
			`OP_OR_RM: begin
				result      = gpr_val | mem_val;
				next_wr_gpr = 1'b1;
			end
			`OP_OR_IMM: begin
				result      = mem_val | immediate_nibble;
				next_wr_mem = 1'b1;
			end
			`OP_AND_RM: begin
				result      = gpr_val & mem_val;
				next_wr_gpr = 1'b1;
			end
			`OP_AND_IMM: begin
				result      = mem_val & immediate_nibble;
				next_wr_mem = 1'b1;
			end
			`OP_XOR_RM: begin
				result      = gpr_val ^ mem_val;
				next_wr_gpr = 1'b1;
			end
			`OP_XOR_IMM: begin
				result      = mem_val ^ immediate_nibble;
				next_wr_mem = 1'b1;
			end
			`OP_SKIP_SET: begin
				is_skip  = 1'b1;
				result   = mem_val & immediate_nibble;
				skip_hit = (result == immediate_nibble);
			end
			`OP_SKIP_CLR: begin
				is_skip  = 1'b1;
				result   = mem_val & immediate_nibble;
				skip_hit = (result == 4'h0);
			end
			default: begin
				result = 4'h0;
			end
		endcase
	end

	// An instruction arriving while a skip is pending runs as a no-op
	wire exec = instr_wr & ~skip_request;

	// Memory writes from execution or from the host data window
	always @(posedge clk) begin
		if (exec && next_wr_mem) begin
			mem[mem_addr] <= result;
		end else if (exec && next_wr_gpr) begin
			mem[gpr_addr] <= result;
		end else if (bus_write && paddr == `OFS_MEM_DATA) begin
			mem[host_addr] <= pwdata[3:0];
		end
	end

	// Flags, skip state and software-visible registers
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			borrow_carry_flag    <= 1'b0;
			zero_flag            <= 1'b0;
			compare_only_flag    <= 1'b0;
			decimal_flag         <= 1'b0;
			index_enable_flag    <= 1'b0;
			index_register_value <= {ADDR_BITS{1'b0}};
			reg_row              <= {ROW_BITS{1'b0}};
			host_addr            <= {ADDR_BITS{1'b0}};
			last_instr           <= 16'h0000;
			last_result          <= 4'h0;
			skip_request         <= 1'b0;
		end else begin
			// Host writes to the flag word
			if (bus_write && paddr == `OFS_FLAGS) begin
				borrow_carry_flag <= pwdata[`FLG_CARRY];
				zero_flag         <= pwdata[`FLG_ZERO];
				compare_only_flag <= pwdata[`FLG_COMPARE];
				decimal_flag      <= pwdata[`FLG_DECIMAL];
				index_enable_flag <= pwdata[`FLG_INDEX_EN];
			end
			// Host writes to index, row and pointer
			if (bus_write && paddr == `OFS_INDEX) begin
				index_register_value <= pwdata[ADDR_BITS-1:0];
			end
			if (bus_write && paddr == `OFS_REG_ROW) begin
				reg_row <= pwdata[ROW_BITS-1:0];
			end
			if (bus_write && paddr == `OFS_MEM_ADDR) begin
				host_addr <= pwdata[ADDR_BITS-1:0];
			end
			if (instr_wr) begin
				last_instr   <= pwdata[15:0];
				skip_request <= exec & is_skip & skip_hit;
			end
			if (exec) begin
				last_result <= result;
			end
			// Subtract flag effects
			if (exec && is_sub) begin
				borrow_carry_flag <= sub_borrow;
				if (sub_diff != 4'h0) begin
					zero_flag <= 1'b0;
				end else if (!compare_only_flag) begin
					zero_flag <= 1'b1;
				end
			end
			// Skip tests drop compare mode
			if (exec && is_skip) begin
				compare_only_flag <= 1'b0;
			end
		end
	end

	// Read mux, captured in the setup phase
	reg [31:0] next_rdata;

	always @* begin
		next_rdata = 32'h0000_0000;
		case (paddr)
			`OFS_INSTR:    next_rdata[15:0] = last_instr;
			`OFS_FLAGS: begin
				next_rdata[`FLG_CARRY]    = borrow_carry_flag;
				next_rdata[`FLG_ZERO]     = zero_flag;
				next_rdata[`FLG_COMPARE]  = compare_only_flag;
				next_rdata[`FLG_DECIMAL]  = decimal_flag;
				next_rdata[`FLG_INDEX_EN] = index_enable_flag;
			end
			`OFS_INDEX:    next_rdata[ADDR_BITS-1:0] = index_register_value;
			`OFS_REG_ROW:  next_rdata[ROW_BITS-1:0] = reg_row;
			`OFS_MEM_ADDR: next_rdata[ADDR_BITS-1:0] = host_addr;
			`OFS_MEM_DATA: next_rdata[3:0] = mem[host_addr];
			`OFS_STATUS: begin
				next_rdata[`STS_SKIP] = skip_request;
				next_rdata[`STS_RES_HI:`STS_RES_LO] = last_result;
			end
			default:       next_rdata = 32'h0000_0000;
		endcase
	end

	// Read data register, loaded at the setup edge
	// so that it stands unchanged through the access phase
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (setup_phase && !pwrite) begin
			prdata <= next_rdata;
		end
	end

endmodule // nibble_alu_logic_skip_ops

// ==== nibble_alu_map.vh ====
/*
 * Register offsets, field positions, opcodes and reset values of the
 * nibble datapath. Assumes it is included by bare name from design files.
 */
`ifndef NIBBLE_ALU_MAP_VH
`define NIBBLE_ALU_MAP_VH

// Byte offsets on the register bus
`define OFS_INSTR     8'h00
`define OFS_FLAGS     8'h04
`define OFS_INDEX     8'h08
`define OFS_REG_ROW   8'h0C
`define OFS_MEM_ADDR  8'h10
`define OFS_MEM_DATA  8'h14
`define OFS_STATUS    8'h18

// Bit positions in the flag register (program status word)
`define FLG_CARRY     0
`define FLG_ZERO      1
`define FLG_COMPARE   2
`define FLG_DECIMAL   3
`define FLG_INDEX_EN  4
`define FLAGS_WIDTH   5
`define FLAGS_RESET   5'h00

// Bit positions in the status register
`define STS_SKIP      0
`define STS_RES_LO    4
`define STS_RES_HI    7

// Instruction word fields
`define INS_OP_HI     15
`define INS_OP_LO     11
`define INS_ROW_HI    10
`define INS_ROW_LO    8
`define INS_COL_HI    7
`define INS_COL_LO    4
`define INS_NIB_HI    3
`define INS_NIB_LO    0

// Major opcodes
`define OP_SUBTRACT_WITH_BORROW_OP_IMM   5'h13
`define OP_AND_RM     5'h04
`define OP_XOR_IMM    5'h15
`define OP_OR_RM      5'h06
`define OP_XOR_RM     5'h05
`define OP_OR_IMM     5'h16
`define OP_AND_IMM    5'h14
`define OP_SKIP_SET   5'h1E
`define OP_SKIP_CLR   5'h1F

// Decimal adjust applied after a borrow
`define BCD_ADJUST    4'hA

`endif

// ==== nibble_sub.v ====
/*
 * One-nibble subtractor with borrow in and out, binary or decimal.
 * Assumes decimal operands are valid digits when decimal is high.
 */
`timescale 1ns/1ps
`include "nibble_alu_map.vh"

module nibble_sub (
	input  wire [3:0] minuend,
	input  wire [3:0] subtrahend,
	input  wire       borrow_in,
	input  wire       decimal,
	output reg  [3:0] difference,
	output reg        borrow_out
);

	reg [4:0] raw;

	// Raw difference, then decimal correction on borrow
	always @* begin
		raw = {1'b0, minuend} - {1'b0, subtrahend} - {4'h0, borrow_in};
		borrow_out = raw[4];
		if (decimal && raw[4]) begin
			difference = raw[3:0] + `BCD_ADJUST;
		end else begin
			difference = raw[3:0];
		end
	end

endmodule // nibble_sub

// ==== nibble_alu_asserts.sv ====
/*
 * Port checker for the nibble datapath, bound into its top module.
 * Assumes one clock, async active-low reset, zero-wait APB slave.
 */
`timescale 1ns/1ps
`include "nibble_alu_map.vh"
module nibble_alu_checker #(
	parameter ROW_BITS = 3,
	parameter COL_BITS = 4
) (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        skip_request,
	input wire logic        borrow_carry_flag
);
	// Decoded access phases
	wire       acc = psel && penable;
	wire       iw  = acc && pwrite && paddr == `OFS_INSTR;
	wire       fw  = acc && pwrite && paddr == `OFS_FLAGS;
	wire [4:0] op  = pwdata[15:11];
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_ready; pready; endproperty
	a_ready: assert property (p_ready) else $error("pready low");
	property p_err; acc && paddr > 8'h18 |-> pslverr; endproperty
	a_err: assert property (p_err) else $error("no error on unmapped address");
	property p_err_only; pslverr |-> acc; endproperty
	a_err_only: assert property (p_err_only) else $error("error outside access");
	property p_cy_cause; $changed(borrow_carry_flag) |-> $past(fw || iw && op == `OP_SUBTRACT_WITH_BORROW_OP_IMM); endproperty
	a_cy_cause: assert property (p_cy_cause) else $error("carry moved alone");
	property p_cy_write; fw |=> borrow_carry_flag == $past(pwdata[`FLG_CARRY]); endproperty
	a_cy_write: assert property (p_cy_write) else $error("carry not written");
	property p_skip_set; $rose(skip_request) |-> $past(iw && op[4:1] == 4'hF); endproperty
	a_skip_set: assert property (p_skip_set) else $error("skip without test");
	property p_skip_clr; iw && skip_request |=> !skip_request; endproperty
	a_skip_clr: assert property (p_skip_clr) else $error("skip not consumed");
	property p_skip_hold; !iw |=> $stable(skip_request); endproperty
	a_skip_hold: assert property (p_skip_hold) else $error("skip moved alone");
	property p_rd_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	// Main scenarios reached
	c_skip: cover property ($rose(skip_request));
	c_cy: cover property ($rose(borrow_carry_flag));
	c_err: cover property (pslverr);
endmodule // nibble_alu_checker
bind nibble_alu_logic_skip_ops nibble_alu_checker #(.ROW_BITS(ROW_BITS), .COL_BITS(COL_BITS)) u_chk (
	.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.skip_request(skip_request), .borrow_carry_flag(borrow_carry_flag));

// ==== test_nibble_alu_logic_skip_ops.sv ====
/*
 * Self-checking bench for the nibble datapath over APB.
 * Assumes the map header and the bound checker are compiled alongside.
 */
`timescale 1ns/1ps
`include "nibble_alu_map.vh"
module test_nibble_alu_logic_skip_ops;
	logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic        pready, pslverr, skip_request, borrow_carry_flag, err;
	int          fails = 0, comparisons = 0;
	logic [4:0]  ops [6] = '{`OP_OR_RM, `OP_AND_RM, `OP_XOR_RM, `OP_OR_IMM, `OP_AND_IMM, `OP_XOR_IMM};
	logic [3:0]  exps [6] = '{4'hE, 4'h2, 4'hC, 4'hE, 4'h2, 4'hC};
	nibble_alu_logic_skip_ops u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .skip_request(skip_request), .borrow_carry_flag(borrow_carry_flag));
	// 200 MHz clock
	initial forever #2.5 clk = ~clk;
	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	// One APB transfer, idle cycle before setup
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 16);
		q = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 16) begin
			fails++;
			give_verdict;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d); bus(1'h1, a, d); endtask
	task automatic rd(input logic [7:0] a); bus(1'h0, a, 32'h0); endtask
	task automatic mem(input logic [6:0] a, input logic [3:0] v);
		wr(`OFS_MEM_ADDR, {25'h0, a});
		wr(`OFS_MEM_DATA, {28'h0, v});
	endtask
	task automatic cmem(input logic [6:0] a, input logic [3:0] e);
		wr(`OFS_MEM_ADDR, {25'h0, a});
		rd(`OFS_MEM_DATA);
		chk("mem", {28'h0, e}, q);
	endtask
	task automatic ex(input logic [4:0] o, input logic [6:0] m, input logic [3:0] n);
		wr(`OFS_INSTR, {16'h0, o, m, n});
	endtask
	task automatic cflg(input logic [4:0] e);
		rd(`OFS_FLAGS);
		chk("flags", {27'h0, e}, q);
		chk("carry pin", {31'h0, e[0]}, {31'h0, borrow_carry_flag});
	endtask
	// Status word and skip pin, looked at after the launching edge has settled
	task automatic cstat(input logic [7:0] e);
		rd(`OFS_STATUS);
		chk("status", {24'h0, e}, q);
		chk("skip pin", {31'h0, e[0]}, {31'h0, skip_request});
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		cflg(5'h00);
		$display("Test reset done");
		// Register and immediate logic forms
		wr(`OFS_REG_ROW, 32'h0);
		for (int i = 0; i < 6; i++) begin
			mem(7'h03, 4'hA);
			mem(7'h2F, 4'h6);
			ex(ops[i], 7'h2F, i < 3 ? 4'h3 : 4'hA);
			cmem(i < 3 ? 7'h03 : 7'h2F, exps[i]);
		end
		$display("Test logic done");
		// Binary subtract, borrow then chained borrow
		wr(`OFS_FLAGS, 32'h0);
		mem(7'h2F, 4'h3);
		ex(`OP_SUBTRACT_WITH_BORROW_OP_IMM, 7'h2F, 4'h5);
		cmem(7'h2F, 4'hE);
		cflg(5'h01);
		mem(7'h2F, 4'h7);
		ex(`OP_SUBTRACT_WITH_BORROW_OP_IMM, 7'h2F, 4'h6);
		cmem(7'h2F, 4'h0);
		cflg(5'h02);
		// Compare only: nothing stored
		wr(`OFS_FLAGS, 32'h6);
		mem(7'h2F, 4'h4);
		ex(`OP_SUBTRACT_WITH_BORROW_OP_IMM, 7'h2F, 4'h4);
		cmem(7'h2F, 4'h4);
		cflg(5'h06);
		mem(7'h2F, 4'h2);
		ex(`OP_SUBTRACT_WITH_BORROW_OP_IMM, 7'h2F, 4'h3);
		cmem(7'h2F, 4'h2);
		cflg(5'h05);
		wr(`OFS_FLAGS, 32'h4);
		mem(7'h2F, 4'h9);
		ex(`OP_SUBTRACT_WITH_BORROW_OP_IMM, 7'h2F, 4'h9);
		cmem(7'h2F, 4'h9);
		cflg(5'h04);
		// Decimal subtract with borrow
		wr(`OFS_FLAGS, 32'h8);
		mem(7'h2F, 4'h2);
		ex(`OP_SUBTRACT_WITH_BORROW_OP_IMM, 7'h2F, 4'h5);
		cmem(7'h2F, 4'h7);
		cflg(5'h09);
		$display("Test subtract done");
		// Indexed operand address
		wr(`OFS_FLAGS, 32'h10);
		wr(`OFS_INDEX, 32'h40);
		mem(7'h6F, 4'hF);
		mem(7'h2F, 4'h0);
		ex(`OP_XOR_IMM, 7'h2F, 4'h5);
		cmem(7'h6F, 4'hA);
		cmem(7'h2F, 4'h0);
		$display("Test index done");
		// Skip tests, suppressed follower
		wr(`OFS_FLAGS, 32'h4);
		mem(7'h13, 4'h5);
		ex(`OP_SKIP_SET, 7'h13, 4'h5);
		cstat(8'h51);
		cflg(5'h00);
		ex(`OP_XOR_IMM, 7'h13, 4'hF);
		cstat(8'h50);
		cmem(7'h13, 4'h5);
		wr(`OFS_FLAGS, 32'h4);
		ex(`OP_SKIP_SET, 7'h13, 4'h6);
		cstat(8'h40);
		cflg(5'h00);
		wr(`OFS_FLAGS, 32'h4);
		ex(`OP_SKIP_CLR, 7'h13, 4'hA);
		cstat(8'h01);
		cflg(5'h00);
		ex(`OP_XOR_IMM, 7'h13, 4'hF);
		cmem(7'h13, 4'h5);
		wr(`OFS_FLAGS, 32'h4);
		ex(`OP_SKIP_CLR, 7'h13, 4'h1);
		cstat(8'h10);
		cflg(5'h00);
		$display("Test skip done");
		// Unmapped address
		rd(8'h1C);
		chk("pslverr", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, q);
		wr(8'h1C, 32'hFFFF);
		chk("pslverr", 32'h1, {31'h0, err});
		$display("Test unmapped done");
		give_verdict;
	end
endmodule // test_nibble_alu_logic_skip_ops
